// ---- design/flpk_lock_status.sv ----
// lock bits, status byte and command gating of the flash sequencer
// assumes an external engine runs program and erase and answers done/fail;
// array read data arrives combinationally for the current command address
`timescale 1ns/1ns
module flpk_lock_status (
    input wire logic clk,
    input wire logic rst,
    input wire flpk_pkg::flpk_cmd_t cmd,
    input wire logic [15:0] array_rdata,
    input wire logic erase_write_mode_zero,
    input wire logic ctrl_we,
    input wire logic ctrl_lock_check_disable,
    input wire logic op_done,
    input wire logic op_fail,
    input wire logic program_mode_strap,
    input wire logic serial_sub_mode2,
    input wire logic reset_pin_n,
    input wire logic boot_check_status,
    input wire logic parallel_mode,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic op_start,
    output flpk_pkg::flpk_op_t op_kind,
    output logic [flpk_pkg::BLK_W-1:0] op_block,
    output logic [flpk_pkg::ADDR_W-1:0] op_addr,
    output logic [15:0] op_wdata,
    output logic seq_ready_flag,
    output logic program_error_flag,
    output logic erase_error_flag,
    output logic lock_check_disable,
    output logic lock_state_result,
    output logic [7:0] flash_status_byte,
    output logic busy_pin_out,
    output logic serial_data_out_pin_pullup_en,
    output logic boot_area_fault
);
    flpk_pkg::flpk_regs_t s;
    flpk_pkg::flpk_regs_t next_s;

    function automatic logic [flpk_pkg::BLK_W-1:0] blk_of(input logic [flpk_pkg::ADDR_W-1:0] a);
        blk_of = a[flpk_pkg::BLK_SHIFT +: flpk_pkg::BLK_W];
    endfunction : blk_of

    // ************************************************************
    // status byte and flags
    // ************************************************************
    // ready from state
    assign seq_ready_flag = (s.st != flpk_pkg::FLPK_BUSY) && (s.st != flpk_pkg::FLPK_LSTAT);
    assign program_error_flag = s.prog_err;
    assign erase_error_flag = s.erase_err;
    assign lock_check_disable = s.lock_check_disable;
    assign lock_state_result = s.lock_result;
    always_comb begin
        flash_status_byte = 8'h00;
        flash_status_byte[flpk_pkg::SR_READY_POS] = seq_ready_flag;
        flash_status_byte[flpk_pkg::SR_ERASE_POS] = s.erase_err;
        flash_status_byte[flpk_pkg::SR_PROG_POS] = s.prog_err;
    end
    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;
    assign op_start = s.op_start;
    assign op_kind = s.op_kind;
    assign op_block = s.op_blk;
    assign op_addr = s.op_addr;
    assign op_wdata = s.op_wdata;
    assign boot_area_fault = s.boot_fault;

    // ************************************************************
    // serial programming pins
    // ************************************************************
    // busy pin per sub-mode
    assign busy_pin_out = serial_sub_mode2 ? boot_check_status : !seq_ready_flag;
    assign serial_data_out_pin_pullup_en = program_mode_strap && !reset_pin_n;

    // ************************************************************
    // command sequencer
    // ************************************************************
    always_comb begin
        logic wr;
        logic rd;
        logic [flpk_pkg::BLK_W-1:0] blk;
        logic [7:0] code;
        logic locked;
        logic any_err;
        wr = cmd.valid && cmd.write;
        rd = cmd.valid && !cmd.write;
        blk = blk_of(cmd.addr);
        code = cmd.wdata[7:0];
        // lock honoured only when checking enabled
        locked = !s.lock_bits[blk] && !s.lock_check_disable;
        any_err = s.prog_err || s.erase_err;
        next_s = s;
        next_s.op_start = 1'b0;
        next_s.rd_valid = 1'b0;
        next_s.boot_fault = 1'b0;
        if (ctrl_we) begin
            next_s.lock_check_disable = ctrl_lock_check_disable;
        end
        // parallel mode flags any access outside the boot area
        if (parallel_mode && cmd.valid && cmd.addr[flpk_pkg::ADDR_W-1 -: 8] != flpk_pkg::BOOT_HI_BYTE) begin
            next_s.boot_fault = 1'b1;
        end
        if (rd) begin
            next_s.rd_valid = 1'b1;
            if (erase_write_mode_zero && s.rmode == flpk_pkg::FLPK_RD_STATUS && !cmd.addr[0]) begin
                next_s.rd_data = {8'h00, flash_status_byte};
            end else begin
                next_s.rd_data = array_rdata;
            end
        end
        case (s.st)
            flpk_pkg::FLPK_IDLE: begin
                if (wr) begin
                    case (code)
                        flpk_pkg::CMD_READ_ARRAY: begin
                            next_s.rmode = flpk_pkg::FLPK_RD_ARRAY;
                        end
                        flpk_pkg::CMD_READ_STATUS: begin
                            next_s.rmode = flpk_pkg::FLPK_RD_STATUS;
                        end
                        flpk_pkg::CMD_CLEAR_STATUS: begin
                            next_s.prog_err = 1'b0;
                            next_s.erase_err = 1'b0;
                        end
                        flpk_pkg::CMD_PROGRAM, flpk_pkg::CMD_BLOCK_ERASE, flpk_pkg::CMD_LOCK_PROGRAM: begin
                            if (!any_err) begin
                                next_s.first_code = code;
                                next_s.first_addr = cmd.addr;
                                next_s.st = flpk_pkg::FLPK_SECOND;
                            end
                        end
                        flpk_pkg::CMD_LOCK_STATUS: begin
                            next_s.first_code = code;
                            next_s.first_addr = cmd.addr;
                            next_s.st = flpk_pkg::FLPK_SECOND;
                        end
                        default: begin
                            next_s.prog_err = 1'b1;
                            next_s.erase_err = 1'b1;
                        end
                    endcase
                end
            end
            flpk_pkg::FLPK_SECOND: begin
                if (wr) begin
                    next_s.st = flpk_pkg::FLPK_IDLE;
                    if (s.first_code == flpk_pkg::CMD_PROGRAM) begin
                        if (cmd.addr == s.first_addr) begin
                            next_s.rmode = flpk_pkg::FLPK_RD_STATUS;
                            if (locked) begin
                                next_s.prog_err = 1'b1;
                                next_s.erase_err = 1'b0;
                            end else begin
                                next_s.op_start = 1'b1;
                                next_s.op_kind = flpk_pkg::FLPK_OP_PROGRAM;
                                next_s.op_blk = blk;
                                next_s.op_addr = cmd.addr;
                                next_s.op_wdata = cmd.wdata;
                                next_s.st = flpk_pkg::FLPK_BUSY;
                            end
                        end else begin
                            next_s.prog_err = 1'b1;
                            next_s.erase_err = 1'b1;
                        end
                    end else if (code == flpk_pkg::CMD_READ_ARRAY && s.first_code != flpk_pkg::CMD_LOCK_STATUS) begin
                        next_s.rmode = flpk_pkg::FLPK_RD_ARRAY;
                    end else if (code == flpk_pkg::CMD_CONFIRM) begin
                        next_s.op_blk = blk;
                        next_s.op_addr = cmd.addr;
                        if (s.first_code == flpk_pkg::CMD_LOCK_STATUS) begin
                            next_s.st = flpk_pkg::FLPK_LSTAT;
                        end else if (s.first_code == flpk_pkg::CMD_BLOCK_ERASE) begin
                            next_s.rmode = flpk_pkg::FLPK_RD_STATUS;
                            if (locked) begin
                                next_s.erase_err = 1'b1;
                                next_s.prog_err = 1'b0;
                            end else begin
                                next_s.op_start = 1'b1;
                                next_s.op_kind = flpk_pkg::FLPK_OP_ERASE;
                                next_s.st = flpk_pkg::FLPK_BUSY;
                            end
                        end else begin
                            next_s.rmode = flpk_pkg::FLPK_RD_STATUS;
                            next_s.op_start = 1'b1;
                            next_s.op_kind = flpk_pkg::FLPK_OP_LOCK;
                            next_s.st = flpk_pkg::FLPK_BUSY;
                        end
                    end else begin
                        next_s.prog_err = 1'b1;
                        next_s.erase_err = 1'b1;
                    end
                end
            end
            flpk_pkg::FLPK_BUSY: begin
                // writes during an operation are ignored
                if (op_done) begin
                    next_s.st = flpk_pkg::FLPK_IDLE;
                    if (op_fail && !s.lock_check_disable) begin
                        if (s.op_kind == flpk_pkg::FLPK_OP_ERASE) begin
                            next_s.erase_err = 1'b1;
                            next_s.prog_err = 1'b0;
                        end else begin
                            next_s.prog_err = 1'b1;
                            next_s.erase_err = 1'b0;
                        end
                    end
                    if (!op_fail) begin
                        if (s.op_kind == flpk_pkg::FLPK_OP_ERASE) begin
                            next_s.lock_bits[s.op_blk] = 1'b1;
                        end else if (s.op_kind == flpk_pkg::FLPK_OP_LOCK) begin
                            next_s.lock_bits[s.op_blk] = 1'b0;
                        end
                    end
                end
            end
            flpk_pkg::FLPK_LSTAT: begin
                next_s.lock_result = s.lock_bits[s.op_blk];
                next_s.st = flpk_pkg::FLPK_IDLE;
            end
            default: begin
                next_s.st = flpk_pkg::FLPK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.st <= flpk_pkg::FLPK_IDLE;
            s.lock_check_disable <= flpk_pkg::LCD_RESET;
            s.lock_bits <= flpk_pkg::LOCK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic wr_c;
    assign wr_c = cmd.valid && cmd.write;

    chk_ready_busy: assert property (s.op_start |-> !seq_ready_flag until_with op_done)
        else $error("ready high during operation");
    chk_status_read: assert property (cmd.valid && !cmd.write && erase_write_mode_zero
        && s.rmode == flpk_pkg::FLPK_RD_STATUS && !cmd.addr[0] |=> rd_valid
        && rd_data == {8'h00, $past(flash_status_byte)})
        else $error("status read returned wrong data");
    chk_clear_flags: assert property (s.st == flpk_pkg::FLPK_IDLE && wr_c
        && cmd.wdata[7:0] == flpk_pkg::CMD_CLEAR_STATUS |=> !program_error_flag && !erase_error_flag)
        else $error("clear status left an error flag");
    // a refused command leaves no sign on the port; only the missing start shows it
    chk_refuse_err: assert property (s.st == flpk_pkg::FLPK_IDLE && wr_c && (s.prog_err || s.erase_err)
        && (cmd.wdata[7:0] == flpk_pkg::CMD_BLOCK_ERASE || cmd.wdata[7:0] == flpk_pkg::CMD_PROGRAM
        || cmd.wdata[7:0] == flpk_pkg::CMD_LOCK_PROGRAM) |=> s.st == flpk_pkg::FLPK_IDLE ##1 !op_start)
        else $error("command accepted while error set");
    chk_seq_err: assert property (s.st == flpk_pkg::FLPK_SECOND && wr_c
        && s.first_code == flpk_pkg::CMD_BLOCK_ERASE && cmd.wdata[7:0] != flpk_pkg::CMD_CONFIRM
        && cmd.wdata[7:0] != flpk_pkg::CMD_READ_ARRAY |=> program_error_flag && erase_error_flag)
        else $error("sequence error not flagged");
    // a locked program fails at once and must never reach the engine
    chk_locked_prog: assert property (s.st == flpk_pkg::FLPK_SECOND && wr_c
        && s.first_code == flpk_pkg::CMD_PROGRAM && cmd.addr == s.first_addr
        && !s.lock_bits[blk_of(cmd.addr)] && !s.lock_check_disable
        |=> program_error_flag && !erase_error_flag && !op_start)
        else $error("locked block program not refused");
    chk_erase_lock: assert property (s.st == flpk_pkg::FLPK_BUSY && op_done && !op_fail
        && s.op_kind == flpk_pkg::FLPK_OP_ERASE |=> s.lock_bits[$past(s.op_blk)])
        else $error("erase left block locked");
    chk_lock_rise: assert property (!(s.st == flpk_pkg::FLPK_BUSY && op_done
        && s.op_kind == flpk_pkg::FLPK_OP_ERASE) |=> (~$past(s.lock_bits) & s.lock_bits) == '0)
        else $error("lock bit set without erase");
    chk_disable_noerr: assert property (s.st == flpk_pkg::FLPK_BUSY && op_done && s.lock_check_disable
        |=> $stable(program_error_flag) && $stable(erase_error_flag))
        else $error("error raised under lock disable");
    chk_err_persist: assert property (!(wr_c && cmd.wdata[7:0] == flpk_pkg::CMD_CLEAR_STATUS)
        && program_error_flag |=> program_error_flag)
        else $error("program error flag lost");
    chk_lstat_ready: assert property (s.st == flpk_pkg::FLPK_LSTAT |-> !seq_ready_flag ##1
        seq_ready_flag && lock_state_result == s.lock_bits[s.op_blk])
        else $error("lock status result wrong");

    cov_erase_ok: cover property (op_done && !op_fail && s.op_kind == flpk_pkg::FLPK_OP_ERASE);
    cov_program_start: cover property (s.op_start && s.op_kind == flpk_pkg::FLPK_OP_PROGRAM);
    cov_lock_status: cover property (s.st == flpk_pkg::FLPK_LSTAT);
    cov_seq_error: cover property ($rose(program_error_flag && erase_error_flag));
endmodule : flpk_lock_status

// ---- design/flpk_pkg.sv ----
// constants, codes and state layout of the flash lock and status logic
// assumes one 100 MHz clock and a command port in the system clock domain
package flpk_pkg;
    localparam int ADDR_W = 20;
    localparam int BLK_W = 4;
    localparam int NUM_BLOCKS = 16;
    localparam int BLK_SHIFT = 12;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
    localparam logic [7:0] CMD_LOCK_STATUS = 8'h71;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam int SR_READY_POS = 7;
    localparam int SR_ERASE_POS = 5;
    localparam int SR_PROG_POS = 4;
    localparam logic [7:0] BOOT_HI_BYTE = 8'hFF;
    localparam logic [NUM_BLOCKS-1:0] LOCK_RESET = '1;
    localparam logic LCD_RESET = 1'b0;

    typedef enum logic [1:0] {
        FLPK_IDLE = 2'b00,
        FLPK_SECOND = 2'b01,
        FLPK_BUSY = 2'b11,
        FLPK_LSTAT = 2'b10
    } flpk_state_t;

    typedef enum logic {FLPK_RD_ARRAY = 1'b0, FLPK_RD_STATUS = 1'b1} flpk_rmode_t;

    typedef enum logic [1:0] {
        FLPK_OP_PROGRAM = 2'b00,
        FLPK_OP_ERASE = 2'b01,
        FLPK_OP_LOCK = 2'b10
    } flpk_op_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } flpk_cmd_t;

    typedef struct packed {
        flpk_state_t st;
        flpk_rmode_t rmode;
        logic [7:0] first_code;
        logic [ADDR_W-1:0] first_addr;
        flpk_op_t op_kind;
        logic [BLK_W-1:0] op_blk;
        logic [ADDR_W-1:0] op_addr;
        logic [15:0] op_wdata;
        logic op_start;
        logic lock_check_disable;
        logic prog_err;
        logic erase_err;
        logic [NUM_BLOCKS-1:0] lock_bits;
        logic lock_result;
        logic [15:0] rd_data;
        logic rd_valid;
        logic boot_fault;
    } flpk_regs_t;
endpackage : flpk_pkg

// ---- testbench/flpk_engine_model.sv ----
// behavioural program/erase engine that answers the sequencer's op_start
// assumes op_start is a one-cycle pulse and only one operation runs at a time
`timescale 1ns/1ns
module flpk_engine_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_start,
    input wire logic [7:0] delay,
    input wire logic fail,
    output logic op_done,
    output logic op_fail
);
    // ****************************************
    // engine timing
    // ****************************************
    logic [7:0] cnt;
    logic busy;

    // op_fail means nothing outside op_done, so it wanders to catch a careless sampler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            busy <= 1'b0;
            op_done <= 1'b0;
            op_fail <= 1'b0;
        end else begin
            op_done <= 1'b0;
            op_fail <= ~op_fail;
            if (op_start) begin
                busy <= 1'b1;
                cnt <= delay;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                op_done <= 1'b1;
                op_fail <= fail;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : flpk_engine_model

// ---- testbench/test_flash_lock_and_status_logic.sv ----
// self-checking bench for the flash lock and status logic
// assumes the engine model answers every op_start; inputs move on falling edges
`timescale 1ns/1ns
module test_flash_lock_and_status_logic;
    // ****************************************
    // signals
    // ****************************************
    logic clk, rst, mode0, ctrl_we, ctrl_lcd, fail, strap, sub2, rpin_n, bchk, par;
    logic rd_valid, op_start, op_done, op_fail, ready, perr, eerr, lcd, lres, busy_pin, pull, bfault;
    logic [7:0] delay, sbyte;
    logic [15:0] rd_data, op_wdata;
    logic [3:0] op_block;
    logic [19:0] op_addr;
    flpk_pkg::flpk_cmd_t cmd;
    flpk_pkg::flpk_op_t op_kind;
    int errors, num_checks, starts, faults, s, i;
    // array content is a simple function of the address so reads can be predicted
    wire [15:0] array_rdata = cmd.addr[15:0] ^ 16'h5A5A;

    flpk_lock_status dut (.clk(clk), .rst(rst), .cmd(cmd), .array_rdata(array_rdata),
        .erase_write_mode_zero(mode0), .ctrl_we(ctrl_we), .ctrl_lock_check_disable(ctrl_lcd),
        .op_done(op_done), .op_fail(op_fail), .program_mode_strap(strap), .serial_sub_mode2(sub2),
        .reset_pin_n(rpin_n), .boot_check_status(bchk), .parallel_mode(par), .rd_data(rd_data),
        .rd_valid(rd_valid), .op_start(op_start), .op_kind(op_kind), .op_block(op_block),
        .op_addr(op_addr), .op_wdata(op_wdata), .seq_ready_flag(ready), .program_error_flag(perr),
        .erase_error_flag(eerr), .lock_check_disable(lcd), .lock_state_result(lres),
        .flash_status_byte(sbyte), .busy_pin_out(busy_pin), .serial_data_out_pin_pullup_en(pull),
        .boot_area_fault(bfault));

    flpk_engine_model engine (.clk(clk), .rst(rst), .op_start(op_start), .delay(delay),
        .fail(fail), .op_done(op_done), .op_fail(op_fail));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (op_start === 1'b1) starts++;
        if (bfault === 1'b1) faults++;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(negedge clk);
        cmd = '{1'b1, 1'b1, a, d};
        @(negedge clk);
        cmd.valid = 1'b0;
    endtask : wr

    // the answer is registered at the taking edge and seen at the next falling edge; the loop only bounds the wait
    task automatic rd(input logic [19:0] a, input logic [15:0] exp, input string what);
        @(negedge clk);
        cmd = '{1'b1, 1'b0, a, 16'h0000};
        @(negedge clk);
        cmd.valid = 1'b0;
        for (i = 0; i < 3 && rd_valid !== 1'b1; i++) @(negedge clk);
        check(16'(rd_valid), 16'h0001, "read answer");
        if (rd_valid !== 1'b1) summarize();
        check(rd_data, exp, what);
    endtask : rd

    task automatic wait_ready;
        for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk);
        if (ready !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: sequencer stuck busy", $time);
            summarize();
        end
    endtask : wait_ready

    task automatic lstat(input logic [19:0] a, input logic exp);
        wr(a, 16'h0071);
        wr(a, 16'h00D0);
        check(16'(ready), 16'h0000, "busy during lock query");
        wait_ready();
        check(16'(lres), 16'(exp), "lock state");
    endtask : lstat

    task automatic set_lcd(input logic v);
        @(negedge clk);
        ctrl_we = 1'b1;
        ctrl_lcd = v;
        @(negedge clk);
        ctrl_we = 1'b0;
        check(16'(lcd), 16'(v), "lock disable control");
    endtask : set_lcd

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        cmd = '0;
        {ctrl_we, ctrl_lcd, fail, strap, sub2, bchk, par} = '0;
        mode0 = 1'b1;
        rpin_n = 1'b1;
        delay = 8'h08;
        {errors, num_checks, starts, faults} = '0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check(16'(sbyte), 16'h0080, "status after reset");
        check(16'(lcd), 16'h0000, "disable after reset");
        lstat(20'h03FFE, 1'b1);
        s = starts;
        wr(20'h03FFE, 16'h0077);
        wr(20'h03FFE, 16'h00D0);
        check(16'(ready), 16'h0000, "busy in lock program");
        wait_ready();
        check(16'(starts - s), 16'h0001, "lock program start");
        check(16'(op_kind), 16'h0002, "lock program kind");
        lstat(20'h03FFE, 1'b0);
        wr(20'h03000, 16'h0040);
        wr(20'h03000, 16'h1234);
        check(16'(sbyte), 16'h0090, "program locked block");
        s = starts;
        wr(20'h04000, 16'h0040);
        // the first word was refused, so the data word arrives as a malformed command
        wr(20'h04000, 16'h1234);
        check(16'(starts - s), 16'h0000, "program while error");
        check(16'(sbyte), 16'h00B0, "error persists");
        wr(20'h00000, 16'h0050);
        check(16'(sbyte), 16'h0080, "clear status");
        wr(20'h00000, 16'h0020);
        wr(20'h03FFE, 16'h00D0);
        check(16'(sbyte), 16'h00A0, "erase locked block");
        wr(20'h00000, 16'h0050);
        wr(20'h00000, 16'h0020);
        wr(20'h03FFE, 16'h0055);
        check(16'(sbyte), 16'h00B0, "bad second cycle");
        wr(20'h00000, 16'h0050);
        s = starts;
        wr(20'h00000, 16'h0020);
        wr(20'h03FFE, 16'h00FF);
        check(16'(sbyte), 16'h0080, "abort by read array");
        check(16'(starts - s), 16'h0000, "abort starts nothing");
        rd(20'h05000, 16'h5A5A ^ 16'h5000, "array after abort");
        wr(20'h05000, 16'h0040);
        wr(20'h05000, 16'hBEEF);
        check(16'(ready), 16'h0000, "busy in program");
        check(16'(busy_pin), 16'h0001, "busy pin in sub-mode one");
        rd(20'h05000, 16'h0000, "status while programming");
        wait_ready();
        check(op_wdata, 16'hBEEF, "program data");
        check(16'(op_block), 16'h0005, "program block");
        rd(20'h05002, 16'h0080, "status after program");
        rd(20'h05001, 16'h5A5A ^ 16'h5001, "odd address reads array");
        mode0 = 1'b0;
        rd(20'h05002, 16'h5A5A ^ 16'h5002, "array outside mode zero");
        mode0 = 1'b1;
        wr(20'h00000, 16'h00FF);
        rd(20'h05000, 16'h5A5A ^ 16'h5000, "array after read array");
        wr(20'h00000, 16'h0070);
        rd(20'h05004, 16'h0080, "read status command");
        fail = 1'b1;
        wr(20'h05000, 16'h0040);
        wr(20'h05000, 16'h0001);
        wait_ready();
        check(16'(sbyte), 16'h0090, "program verify fail");
        wr(20'h00000, 16'h0050);
        wr(20'h00000, 16'h0020);
        wr(20'h05FFE, 16'h00D0);
        wait_ready();
        check(16'(sbyte), 16'h00A0, "erase verify fail");
        wr(20'h00000, 16'h0050);
        set_lcd(1'b1);
        s = starts;
        wr(20'h03000, 16'h0040);
        wr(20'h03000, 16'h0002);
        wait_ready();
        check(16'(starts - s), 16'h0001, "locked block open");
        check(16'(sbyte), 16'h0080, "no error when disabled");
        set_lcd(1'b0);
        wr(20'h03000, 16'h0040);
        wr(20'h03000, 16'h0002);
        check(16'(sbyte), 16'h0090, "lock retained");
        wr(20'h00000, 16'h0050);
        fail = 1'b0;
        set_lcd(1'b1);
        wr(20'h00000, 16'h0020);
        wr(20'h03FFE, 16'h00D0);
        wait_ready();
        check(16'(op_kind), 16'h0001, "erase under disable");
        set_lcd(1'b0);
        lstat(20'h03FFE, 1'b1);
        // programmer side: reset pin low while the clock keeps running
        strap = 1'b1;
        rpin_n = 1'b0;
        repeat (20) @(negedge clk);
        check(16'(pull), 16'h0001, "pull-up through programmer reset");
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            {rpin_n, strap} = 2'(k);
            sub2 = rpin_n;
            bchk = ~strap;
            #1;
            check(16'(pull), 16'(strap & ~rpin_n), "serial pull-up");
            // the sequencer is idle here, so sub-mode one shows not busy
            check(16'(busy_pin), 16'(sub2 ? bchk : 1'b0), "busy pin");
        end
        // array mode first, so the boot area reads return array words
        wr(20'h00000, 16'h00FF);
        par = 1'b1;
        s = faults;
        rd(20'hFF000, 16'h5A5A ^ 16'hF000, "boot area read");
        @(negedge clk);
        check(16'(faults - s), 16'h0000, "inside boot area");
        rd(20'h3F000, 16'h5A5A ^ 16'hF000, "outside boot area");
        @(negedge clk);
        check(16'(faults - s), 16'h0001, "boot area fault");
        summarize();
    end
endmodule : test_flash_lock_and_status_logic
